// ### hdl/edc_mode_regs.sv
// mode-register decode and error-detect pin stream, with its check-code queue
// assumes commands and states arrive decoded on clk_sys from the command logic
// Operation
// - bank groups off makes same-group gap equal cross-group gap
// - hold pattern field resets to all ones
// - hold pattern repeats every 4 unit intervals on the detect pins
// - enabled check-code bursts replace the hold pattern while they last
// - enabled pseudo-random feature replaces the hold pattern
// - some writes leave the hold pattern undefined for the update delay
// - no hold pattern in training, self refresh, reset, gated power-down, high-z
// - invert bit inverts second pin hold or pseudo-random pattern, never check bursts
// - read latency code 00 means 4, others their value
// - write latency codes 000-010 mean 15-17, 011-111 mean 10-14
// - read check enable is active low; off means hold pattern stays
// - write check enable is active low; off means hold pattern stays
// - low-power options act independently; clock gating support optional
// - clock gate set lets write_clock receivers switch off in power-down
// - five-bit sub-address selects lane, inversion lane or whole byte
// - address 0110 selects reference register, 1001 equalizer register
// - sub-address 01010 sets byte-0 output equalizer from two low bits
// - four-bit feedback equalizer code, zero off, stored per lane
// - sub-address 11010 sets byte-1 output equalizer from two low bits
`timescale 1ns/1ps
`include "edc_mode_params.svh"

module check_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] count_ff;
  logic push;
  logic pop;

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : bad_depth
    $error("check_fifo depth must be a power of two, at least 2");
  end

  assign in_ready = count_ff != (AW+1)'(DEPTH);
  assign out_valid = count_ff != '0;
  assign out_data = mem_ff[rd_ptr_ff];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
      if (push && !pop) begin
        count_ff <= count_ff + 1'b1;
      end else if (pop && !push) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end
endmodule

module edc_mode_regs #(
  parameter int LANES = 18,
  parameter int CODE_W = 8,
  parameter int FIFO_DEPTH = 8,
  parameter int MODE_UPDATE_CYCLES = `MODE_UPDATE_CYCLES,
  parameter bit PRBS_PRESENT = 1'b1,
  parameter bit PDCG_PRESENT = 1'b1
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic mrw_valid,
  input wire logic [3:0] mrw_addr,
  input wire logic [11:0] mrw_op,
  input wire logic chk_valid,
  output logic chk_ready,
  input wire logic chk_is_write,
  input wire logic [CODE_W-1:0] chk_code,
  input wire logic ca_training,
  input wire logic write_clock_alignment,
  input wire logic self_refresh,
  input wire logic power_down,
  input wire logic edc_hiz,
  output logic [1:0] error_detect_pins,
  output logic [1:0] error_detect_oe,
  output logic hold_undefined,
  output logic [2:0] same_group_column_gap,
  output logic [2:0] cross_group_column_gap,
  output logic rd_check_on,
  output logic wr_check_on,
  output logic [2:0] read_check_latency,
  output logic [4:0] write_check_latency,
  output logic power_down_clock_gate,
  output logic refresh_command_lockout,
  output logic write_clock_rx_off,
  output logic prbs_on,
  output logic [LANES*7-1:0] data_input_reference,
  output logic [LANES*4-1:0] feedback_equalizer,
  output logic [1:0] output_equalizer_byte0,
  output logic [1:0] output_equalizer_byte1
);
  localparam int ENTRY_W = CODE_W + 8;
  localparam int CW = $clog2(CODE_W);
  localparam int MW = $clog2(MODE_UPDATE_CYCLES + 1);

  if (LANES != 18 || CODE_W < 2 || MODE_UPDATE_CYCLES < 1) begin : bad_params
    $error("edc_mode_regs needs 18 lanes, a code of 2+ bits, a nonzero update delay");
  end

  edc_mode_pkg::op_t edc_cfg_ff;
  logic [1:0] bank_cfg_ff;
  logic [1:0] lp_cfg_ff;
  logic prbs_en_ff;
  logic [`DRIVE_LOW_MSB:0] drive_low_ff;
  logic [MW-1:0] undef_cnt_ff;
  logic [7:0] now_ff;
  logic [1:0] ui_ff;
  logic [6:0] lfsr_ff;
  edc_mode_pkg::emit_state_t emit_state_ff;
  logic [CODE_W-1:0] shift_ff;
  logic [CW-1:0] bit_cnt_ff;
  logic [1:0] pins_ff;
  logic [1:0] oe_ff;

  logic wr_edc;
  logic wr_vref;
  logic wr_eq;
  logic [4:0] sub_addr;
  logic undef_trigger;
  logic want_push;
  logic fifo_in_valid;
  logic [ENTRY_W-1:0] fifo_in;
  logic head_valid;
  logic [ENTRY_W-1:0] head;
  logic [7:0] head_age;
  logic head_due;
  logic head_pop;
  logic [4:0] kind_latency;
  logic suppress;
  logic hold_bit;
  logic bg_bit;

  assign wr_edc = mrw_valid && mrw_addr == `MRW_EDC;
  assign wr_vref = mrw_valid && mrw_addr == `MRW_VREF;
  assign wr_eq = mrw_valid && mrw_addr == `MRW_EQ;
  assign sub_addr = mrw_op[`SUB_MSB:`SUB_LSB];

  // decoded settings
  assign rd_check_on = ~edc_cfg_ff[`RD_OFF_BIT];
  assign wr_check_on = ~edc_cfg_ff[`WR_OFF_BIT];
  assign read_check_latency = (edc_cfg_ff[`RCL_MSB:`RCL_LSB] == 2'h0) ? `RCL_ZERO_MAP
    : {1'b0, edc_cfg_ff[`RCL_MSB:`RCL_LSB]};
  assign write_check_latency = (edc_cfg_ff[`WCL_MSB:`WCL_LSB] < `WCL_LOW_LIMIT)
    ? `WCL_LOW_BASE + {2'h0, edc_cfg_ff[`WCL_MSB:`WCL_LSB]}
    : `WCL_HIGH_BASE + {2'h0, edc_cfg_ff[`WCL_MSB:`WCL_LSB]};
  assign cross_group_column_gap = `GAP_CROSS;
  assign same_group_column_gap = !bank_cfg_ff[1] ? `GAP_CROSS
    : (bank_cfg_ff[0] ? `GAP_BG_SEL1 : `GAP_BG_SEL0);
  assign power_down_clock_gate = lp_cfg_ff[0] & PDCG_PRESENT;
  assign refresh_command_lockout = lp_cfg_ff[1];
  assign write_clock_rx_off = power_down & power_down_clock_gate;
  assign prbs_on = prbs_en_ff & PRBS_PRESENT;
  assign hold_undefined = undef_cnt_ff != '0;
  assign error_detect_pins = pins_ff;
  assign error_detect_oe = oe_ff;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      edc_cfg_ff <= `EDC_CFG_RESET;
    end else if (wr_edc) begin
      edc_cfg_ff <= mrw_op;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bank_cfg_ff <= 2'h0;
      lp_cfg_ff <= 2'h0;
      prbs_en_ff <= 1'b0;
      drive_low_ff <= '0;
    end else if (mrw_valid) begin
      if (mrw_addr == `MRW_BANK) begin
        bank_cfg_ff <= {mrw_op[`BG_EN_BIT], mrw_op[`BG_SEL_BIT]};
      end
      if (mrw_addr == `MRW_LP) begin
        lp_cfg_ff <= {mrw_op[`LOCK_BIT], mrw_op[`PDCG_BIT]};
      end
      if (mrw_addr == `MRW_TEST) begin
        prbs_en_ff <= mrw_op[`PRBS_BIT];
      end
      if (mrw_addr == `MRW_DRIVE) begin
        drive_low_ff <= mrw_op[`DRIVE_LOW_MSB:0];
      end
    end
  end

  // writes after which the pin pattern is not guaranteed
  always_comb begin
    undef_trigger = 1'b0;
    if (wr_edc && (mrw_op[`HOLD_MSB:0] != edc_cfg_ff[`HOLD_MSB:0]
        || mrw_op[`INV_BIT:`RD_OFF_BIT] != edc_cfg_ff[`INV_BIT:`RD_OFF_BIT])) begin
      undef_trigger = 1'b1;
    end
    if (mrw_valid && mrw_addr == `MRW_DRIVE && mrw_op[`DRIVE_LOW_MSB:0] != drive_low_ff) begin
      undef_trigger = 1'b1;
    end
    if (wr_vref && ((sub_addr == `SA_TXEQ0 && mrw_op[`TXEQ_MSB:0] != output_equalizer_byte0)
        || (sub_addr == `SA_TXEQ1 && mrw_op[`TXEQ_MSB:0] != output_equalizer_byte1))) begin
      undef_trigger = 1'b1;
    end
    if (mrw_valid && mrw_addr == `MRW_TEST && prbs_en_ff && !mrw_op[`PRBS_BIT]) begin
      undef_trigger = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      undef_cnt_ff <= '0;
    end else if (undef_trigger) begin
      undef_cnt_ff <= MW'(MODE_UPDATE_CYCLES);
    end else if (undef_cnt_ff != '0) begin
      undef_cnt_ff <= undef_cnt_ff - 1'b1;
    end
  end

  // output equalizer per byte
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      output_equalizer_byte0 <= 2'h0;
      output_equalizer_byte1 <= 2'h0;
    end else if (wr_vref) begin
      if (sub_addr == `SA_TXEQ0) begin
        output_equalizer_byte0 <= mrw_op[`TXEQ_MSB:0];
      end
      if (sub_addr == `SA_TXEQ1) begin
        output_equalizer_byte1 <= mrw_op[`TXEQ_MSB:0];
      end
    end
  end

  // per-lane reference and feedback equalizer storage
  for (genvar g = 0; g < LANES; g++) begin : lane
    localparam logic [4:0] LANE_SA = (g < 8) ? 5'(g) : (g == 8) ? `SA_INV0
      : (g < 17) ? `SA_DQ8 + 5'(g - 9) : `SA_INV1;
    localparam logic [4:0] BYTE_SA = (g < 9) ? `SA_BYTE0 : `SA_BYTE1;
    logic hit;
    assign hit = sub_addr == LANE_SA || sub_addr == BYTE_SA;
    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        data_input_reference[g*7 +: 7] <= 7'h0;
        feedback_equalizer[g*4 +: 4] <= 4'h0;
      end else begin
        if (wr_vref && hit) begin
          data_input_reference[g*7 +: 7] <= mrw_op[`VREF_MSB:0];
        end
        if (wr_eq && hit) begin
          feedback_equalizer[g*4 +: 4] <= mrw_op[`DFE_MSB:0];
        end
      end
    end
  end

  // check-code queue, each entry tagged with the cycle it falls due
  assign kind_latency = chk_is_write ? write_check_latency : {2'h0, read_check_latency};
  assign want_push = chk_is_write ? wr_check_on : rd_check_on;
  assign fifo_in_valid = chk_valid & want_push;
  assign fifo_in = {chk_code, now_ff + {3'h0, kind_latency}};
  assign head_age = now_ff - head[7:0];
  assign head_due = head_valid && !head_age[7];
  assign head_pop = head_due && emit_state_ff == edc_mode_pkg::EMIT_HOLD;

  check_fifo #(
    .WIDTH(ENTRY_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .rst(rst),
    .in_valid(fifo_in_valid),
    .in_ready(chk_ready),
    .in_data(fifo_in),
    .out_valid(head_valid),
    .out_ready(head_pop),
    .out_data(head)
  );

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      now_ff <= 8'h0;
      ui_ff <= 2'h0;
      lfsr_ff <= `PRBS_SEED;
    end else begin
      now_ff <= now_ff + 1'b1;
      ui_ff <= ui_ff + 1'b1;
      lfsr_ff <= {lfsr_ff[5:0], lfsr_ff[6] ^ lfsr_ff[5]};
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      emit_state_ff <= edc_mode_pkg::EMIT_HOLD;
      shift_ff <= '0;
      bit_cnt_ff <= '0;
    end else begin
      unique case (emit_state_ff)
        edc_mode_pkg::EMIT_HOLD: begin
          if (head_pop) begin
            emit_state_ff <= edc_mode_pkg::EMIT_CHECK;
            shift_ff <= head[ENTRY_W-1:8];
            bit_cnt_ff <= CW'(CODE_W - 1);
          end
        end
        edc_mode_pkg::EMIT_CHECK: begin
          shift_ff <= shift_ff >> 1;
          bit_cnt_ff <= bit_cnt_ff - 1'b1;
          if (bit_cnt_ff == '0) begin
            emit_state_ff <= edc_mode_pkg::EMIT_HOLD;
          end
        end
      endcase
    end
  end

  // pin drive
  assign suppress = ca_training | write_clock_alignment | self_refresh | edc_hiz
    | (power_down & power_down_clock_gate);
  assign hold_bit = edc_cfg_ff[ui_ff];
  assign bg_bit = prbs_on ? lfsr_ff[6] : hold_bit;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pins_ff <= 2'h0;
      oe_ff <= 2'h0;
    end else if (suppress) begin
      pins_ff <= 2'h0;
      oe_ff <= 2'h0;
    end else if (emit_state_ff == edc_mode_pkg::EMIT_CHECK) begin
      pins_ff <= {2{shift_ff[0]}};
      oe_ff <= 2'h3;
    end else begin
      pins_ff <= {bg_bit ^ edc_cfg_ff[`INV_BIT], bg_bit};
      oe_ff <= 2'h3;
    end
  end
endmodule

// ### shared/edc_mode_params.svh
// offsets, field positions, reset values and timing counts of the mode-register block
// included by the design file; definitions only
`ifndef EDC_MODE_PARAMS_SVH
`define EDC_MODE_PARAMS_SVH
// mode_register_write address codes
`define MRW_DRIVE 4'h1
`define MRW_BANK 4'h3
`define MRW_EDC 4'h4
`define MRW_LP 4'h5
`define MRW_VREF 4'h6
`define MRW_EQ 4'h9
`define MRW_TEST 4'hC
// edc_config_reg fields
`define EDC_CFG_RESET 12'h60F
`define HOLD_MSB 3
`define WCL_MSB 6
`define WCL_LSB 4
`define RCL_MSB 8
`define RCL_LSB 7
`define RD_OFF_BIT 9
`define WR_OFF_BIT 10
`define INV_BIT 11
// other single-bit fields and the two-bit drive field
`define BG_EN_BIT 11
`define BG_SEL_BIT 10
`define PDCG_BIT 1
`define LOCK_BIT 2
`define PRBS_BIT 2
`define DRIVE_LOW_MSB 1
// per-pin fields and sub-addresses
`define SUB_MSB 11
`define SUB_LSB 7
`define VREF_MSB 6
`define DFE_MSB 3
`define TXEQ_MSB 1
`define SA_INV0 5'h08
`define SA_TXEQ0 5'h0A
`define SA_BYTE0 5'h0F
`define SA_DQ8 5'h10
`define SA_INV1 5'h18
`define SA_TXEQ1 5'h1A
`define SA_BYTE1 5'h1F
// latency maps
`define RCL_ZERO_MAP 3'h4
`define WCL_LOW_LIMIT 3'h3
`define WCL_LOW_BASE 5'hF
`define WCL_HIGH_BASE 5'h7
// column gaps in clocks
`define GAP_BG_SEL1 3'h3
`define GAP_BG_SEL0 3'h4
`define GAP_CROSS 3'h2
// timing and stream
`define MODE_UPDATE_CYCLES 16
`define PRBS_SEED 7'h7F
`endif

// ### shared/edc_mode_pkg.sv
// types of the mode-register and error-detect block
// no assumptions beyond a SystemVerilog compiler
package edc_mode_pkg;
  typedef enum logic {
    EMIT_HOLD = 1'b0,
    EMIT_CHECK = 1'b1
  } emit_state_t;
  typedef logic [11:0] op_t;
endpackage

// ### tb/check_source.sv
// controller model: offers check codes and holds each until taken
// assumes the bench fills it through push
`timescale 1ns/1ps
module check_source (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic chk_ready,
  output logic chk_valid,
  output logic chk_is_write,
  output logic [7:0] chk_code,
  output logic saw_full
);
  logic [8:0] q[$];
  logic took;
  initial begin
    chk_valid = 1'b0;
    chk_is_write = 1'b0;
    chk_code = 8'h00;
    saw_full = 1'b0;
    took = 1'b0;
  end
  task automatic push(input logic w, input logic [7:0] c);
    q.push_back({w, c});
  endtask
  always @(posedge clk_sys) begin
    took <= chk_valid && chk_ready;
    if (chk_valid && !chk_ready) saw_full <= 1'b1;
  end
  // only codes offered, never column or training commands
  always @(negedge clk_sys) begin
    if (took) void'(q.pop_front());
    if (!rst && q.size() > 0) begin
      chk_valid = 1'b1;
      chk_is_write = q[0][8];
      chk_code = q[0][7:0];
    end else begin
      chk_valid = 1'b0;
      chk_code = ~chk_code;
    end
  end
endmodule

// ### tb/edc_mode_monitor.sv
// concurrent checks on the mode-register block's ports
// bound to edc_mode_regs; one clock, async high reset
`timescale 1ns/1ps
module edc_mode_monitor (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic mrw_valid,
  input wire logic [3:0] mrw_addr,
  input wire logic [11:0] mrw_op,
  input wire logic chk_valid,
  input wire logic chk_ready,
  input wire logic ca_training,
  input wire logic write_clock_alignment,
  input wire logic self_refresh,
  input wire logic power_down,
  input wire logic edc_hiz,
  input wire logic [1:0] error_detect_pins,
  input wire logic [1:0] error_detect_oe,
  input wire logic [2:0] same_group_column_gap,
  input wire logic [2:0] cross_group_column_gap,
  input wire logic rd_check_on,
  input wire logic wr_check_on,
  input wire logic [2:0] read_check_latency,
  input wire logic [4:0] write_check_latency,
  input wire logic power_down_clock_gate,
  input wire logic refresh_command_lockout,
  input wire logic write_clock_rx_off,
  input wire logic [1:0] output_equalizer_byte0,
  input wire logic hold_undefined,
  input wire logic prbs_on
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic bank_w;
  logic edc_w;
  assign bank_w = mrw_valid && mrw_addr == 4'h3;
  assign edc_w = mrw_valid && mrw_addr == 4'h4;
  a_bg_off_gap: assert property (bank_w && !mrw_op[11] |=> same_group_column_gap == cross_group_column_gap)
    else $error("same-group gap differs from cross-group gap");
  a_bg_on_gap: assert property (bank_w && mrw_op[11] |-> ##1 same_group_column_gap == ($past(mrw_op[10]) ? 3 : 4))
    else $error("same-group gap wrong with groups on");
  a_rd_lat_map: assert property (edc_w |=> read_check_latency == ($past(mrw_op[8:7]) == 0 ? 4 : $past(mrw_op[8:7])))
    else $error("read check latency decode wrong");
  a_wr_lat_map: assert property (edc_w |=> write_check_latency == $past(mrw_op[6:4]) + ($past(mrw_op[6:4]) < 3 ? 15 : 7))
    else $error("write check latency decode wrong");
  a_check_enables: assert property (edc_w |=> rd_check_on != $past(mrw_op[9]) && wr_check_on != $past(mrw_op[10]))
    else $error("check enable polarity wrong");
  a_lp_bits: assert property (mrw_valid && mrw_addr == 4'h5 |=> {refresh_command_lockout, power_down_clock_gate} == $past(mrw_op[2:1]))
    else $error("low-power bits not independent");
  a_rx_gate: assert property (write_clock_rx_off == (power_down && power_down_clock_gate))
    else $error("write clock receiver gating wrong");
  a_pins_quiet: assert property (ca_training || write_clock_alignment || self_refresh || edc_hiz
    || power_down && power_down_clock_gate |=> error_detect_oe == 2'h0 && error_detect_pins == 2'h0)
    else $error("detect pins driven while suppressed");
  a_txeq_byte: assert property (mrw_valid && mrw_addr == 4'h6 && mrw_op[11:7] == 5'h0a
    |=> output_equalizer_byte0 == $past(mrw_op[1:0]))
    else $error("byte 0 output equalizer not set");
  a_prbs_enable: assert property (mrw_valid && mrw_addr == 4'hc |=> prbs_on == $past(mrw_op[2]))
    else $error("pseudo-random enable not taken");
  a_undef_prbs_off: assert property (mrw_valid && mrw_addr == 4'hc && prbs_on && !mrw_op[2] |=> hold_undefined)
    else $error("no undefined window after pseudo-random disable");
  cover property (edc_w);
  cover property (chk_valid && !chk_ready);
  cover property (power_down && power_down_clock_gate);
endmodule
bind edc_mode_regs edc_mode_monitor u_mon (.*);

// ### tb/edc_mode_regs_tb.sv
// self-checking bench for the mode-register and detect-pin block
// assumes check_source as far side and the bound monitor
`timescale 1ns/1ps
module edc_mode_regs_tb;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic mrw_valid = 1'b0;
  logic [3:0] mrw_addr = 4'h0;
  logic [11:0] mrw_op = 12'h000;
  logic ca_training = 0, write_clock_alignment = 0, self_refresh = 0, power_down = 0, edc_hiz = 0;
  logic chk_valid, chk_ready, chk_is_write, saw_full, hit, watch = 1'b0;
  logic hold_undefined, rd_check_on, wr_check_on, power_down_clock_gate, refresh_command_lockout;
  logic write_clock_rx_off, prbs_on;
  logic [1:0] error_detect_pins, error_detect_oe, output_equalizer_byte0, output_equalizer_byte1;
  logic [2:0] same_group_column_gap, cross_group_column_gap, read_check_latency;
  logic [4:0] write_check_latency;
  logic [125:0] data_input_reference;
  logic [71:0] feedback_equalizer;
  logic [7:0] chk_code, got, w, exp_q[$];
  logic [31:0] seed = 32'h2299;
  logic [11:0] op;
  logic [6:0] v;
  logic [3:0] s;
  logic [4:0] sub_t[4] = '{5'h05, 5'h08, 5'h13, 5'h18};
  int lane_t[4] = '{5, 8, 12, 17};
  int n_errors = 0;
  int check_count = 0;
  edc_mode_regs #(.MODE_UPDATE_CYCLES(2)) dut (.*);
  check_source u_src (.*);
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic cmp(input string name, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s expected %0h seen %0h", name, e, g);
    end
  endtask
  task automatic mrw(input logic [3:0] a, input logic [11:0] o);
    @(negedge clk_sys);
    mrw_valid = 1'b1;
    mrw_addr = a;
    mrw_op = o;
    @(negedge clk_sys);
    mrw_valid = 1'b0;
  endtask
  task automatic complete_run();
    if (n_errors == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial forever #5 clk_sys = ~clk_sys;
  initial begin
    #100us;
    n_errors++;
    complete_run();
  end
  // burst watcher: hold pattern is zero, so a one on pin 0 opens a burst
  always begin
    @(negedge clk_sys);
    if (watch && error_detect_oe === 2'h3 && error_detect_pins[0] === 1'b1) begin
      for (int b = 0; b < 8; b++) begin
        got[b] = error_detect_pins[0];
        cmp("second_pin", error_detect_pins[0], error_detect_pins[1]);
        if (b < 7) @(negedge clk_sys);
      end
      cmp("burst", exp_q.size() > 0 ? {24'h0, exp_q.pop_front()} : 32'hxxxx_xxxx, {24'h0, got});
    end
  end
  initial begin
    repeat (8) @(negedge clk_sys);
    rst = 1'b0;
    @(negedge clk_sys);
    repeat (4) begin
      @(negedge clk_sys);
      cmp("hold_reset", 2'h3, error_detect_pins);
    end
    for (int i = 0; i < 8; i++) begin
      op = {1'b0, i[0], i[1], i[1:0], i[2:0], 4'hf};
      mrw(4'h4, op);
      cmp("rd_lat", i[1:0] == 0 ? 4 : i[1:0], read_check_latency);
      cmp("wr_lat", i < 3 ? 15 + i : 7 + i, write_check_latency);
      cmp("rd_on", !op[9], rd_check_on);
      cmp("wr_on", !op[10], wr_check_on);
    end
    op = {8'h60, 4'(rnd())};
    mrw(4'h4, op);
    repeat (3) @(negedge clk_sys);
    for (int k = 0; k < 4; k++) begin
      s[k] = error_detect_pins[0];
      @(negedge clk_sys);
    end
    w = {op[3:0], op[3:0]};
    hit = 1'b0;
    for (int r = 0; r < 4; r++) if (w[r +: 4] == s) hit = 1'b1;
    cmp("hold_shift", 1, hit);
    for (int i = 0; i < 4; i++) begin
      mrw(4'h3, {i[1:0], 10'h0});
      cmp("same_gap", i[1] ? (i[0] ? 3 : 4) : 2, same_group_column_gap);
      cmp("cross_gap", 2, cross_group_column_gap);
    end
    power_down = 1'b1;
    for (int i = 0; i < 4; i++) begin
      mrw(4'h5, {9'h0, i[1:0], 1'b0});
      cmp("lp_bits", i[1:0], {refresh_command_lockout, power_down_clock_gate});
      cmp("rx_off", i[0], write_clock_rx_off);
    end
    power_down = 1'b0;
    for (int i = 0; i < 4; i++) begin
      {edc_hiz, self_refresh, write_clock_alignment, ca_training} = 4'h1 << i;
      repeat (2) @(negedge clk_sys);
      cmp("oe_quiet", 0, error_detect_oe);
    end
    {edc_hiz, self_refresh, write_clock_alignment, ca_training} = 4'h0;
    for (int k = 0; k < 4; k++) begin
      v = 7'(rnd() % 96);
      mrw(4'h6, {sub_t[k], v});
      cmp("vref", v, data_input_reference[lane_t[k]*7 +: 7]);
    end
    op = 12'(rnd());
    mrw(4'h9, {5'h1f, 3'h0, op[3:0]});
    for (int g = 9; g < 17; g++) cmp("dfe", op[3:0], feedback_equalizer[g*4 +: 4]);
    cmp("dfe_keep", 0, feedback_equalizer[5*4 +: 4]);
    mrw(4'h6, {5'h09, 7'h00});
    cmp("vref_keep", v, data_input_reference[17*7 +: 7]);
    mrw(4'h6, {5'h0a, 5'h0, op[5:4]});
    cmp("txeq0", op[5:4], output_equalizer_byte0);
    mrw(4'h6, {5'h1a, 5'h0, op[7:6]});
    cmp("txeq1", op[7:6], output_equalizer_byte1);
    mrw(4'h4, 12'h8b0);
    repeat (4) @(negedge clk_sys);
    cmp("inv_hold", 2'h2, error_detect_pins);
    // pseudo-random stream replaces the all-zero hold pattern
    mrw(4'hc, 12'h004);
    cmp("prbs_on", 1, prbs_on);
    w = 8'h00;
    for (int k = 0; k < 8; k++) begin
      @(negedge clk_sys);
      w[k] = error_detect_pins[0];
      cmp("prbs_inv", !error_detect_pins[0], error_detect_pins[1]);
    end
    cmp("prbs_seen", 1, |w);
    mrw(4'hc, 12'h000);
    cmp("prbs_off", 0, prbs_on);
    cmp("undef_on", 1, hold_undefined);
    repeat (2) @(negedge clk_sys);
    cmp("undef_off", 0, hold_undefined);
    mrw(4'h1, 12'h001);
    cmp("undef_drive", 1, hold_undefined);
    repeat (2) @(negedge clk_sys);
    mrw(4'h1, 12'h001);
    cmp("undef_same", 0, hold_undefined);
    watch = 1'b1;
    for (int k = 0; k < 10; k++) begin
      op = 12'(rnd()) | 12'h001;
      exp_q.push_back(op[7:0]);
      u_src.push(k[0], op[7:0]);
    end
    repeat (400) begin
      if (exp_q.size() == 0) break;
      @(negedge clk_sys);
    end
    cmp("drained", 0, exp_q.size());
    cmp("refused", 1, saw_full);
    mrw(4'h4, 12'he30);
    u_src.push(1'b1, 8'hff);
    u_src.push(1'b0, 8'hff);
    repeat (40) @(negedge clk_sys);
    cmp("idle_pins", 2'h2, error_detect_pins);
    // second reset in mid-run must restore the all-ones hold pattern
    watch = 1'b0;
    rst = 1'b1;
    repeat (2) @(negedge clk_sys);
    cmp("oe_reset", 0, error_detect_oe);
    rst = 1'b0;
    repeat (2) @(negedge clk_sys);
    cmp("hold_rearm", 2'h3, error_detect_pins);
    cmp("undef_clear", 0, hold_undefined);
    cmp("rd_off_rearm", 0, rd_check_on);
    complete_run();
  end
endmodule
